/* hdl/pnsa_host_ctrl.sv */
`timescale 1ns/10ps
`include "pnsa_regs.svh"
// Notes on behaviour
// - Sleep: motor off, command_a on, motor on, then speed field zero.
// - Program only with motor stopped; power-cycle and read back afterwards. The controller does neither; it ends after clearing motor_disable.
// - Wait at least 10 ms after wake before any store access.
// - Set motor_disable before store access; driver stops the motor meanwhile.
// - Clear the unlock key with 0x0000 before writing the key.
// - Write 0xC0DE to the key; access only allowed after it.
// - Read nvm_ready_flag as one before issuing an operation.
// - Mass write first loads all shadows 0x90 through 0x96.
// - Mass write command: shadow 0, reload 0, write select 1, kind 10.
// - Afterwards clear motor_disable to restore motor driving; a poll timeout skips this and leaves it set.
module pnsa_host_ctrl
   import pnsa_pkg::*;
#(
   parameter int WAKE_WAIT_CYCLES = `PNSA_WAKE_WAIT_CYCLES,
   parameter int POLL_LIMIT = `PNSA_POLL_LIMIT,
   parameter logic [6:0] DEV_ADDR = `PNSA_DEV_ADDR,
   parameter int SCL_QUARTER = `PNSA_SCL_QUARTER_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire pnsa_cmd_t cmd_kind_i,
   input wire logic [7:0] cmd_addr_i,
   input wire logic [15:0] cmd_data_i,
   input wire logic [111:0] param_wdata_i,
   input wire logic sda_i,
   output logic cmd_ready_o,
   output logic cmd_done_o,
   output logic cmd_error_o,
   output logic [15:0] rdata_o,
   output logic [111:0] param_rdata_o,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o
);

   localparam logic [15:0] MOTOR_OFF = 16'(1 << `PNSA_MOTOR_DISABLE_BIT);
   localparam logic [15:0] SPEED_ZERO_A = 16'(1 << `PNSA_COMMAND_A_BIT);
   localparam logic [15:0] MASS_RD_CTRL =
      16'({14'h0000, `PNSA_ACCESS_KIND_MASS} << `PNSA_ACCESS_KIND_LSB);
   localparam logic [15:0] MASS_WR_CTRL =
      MASS_RD_CTRL | 16'(1 << `PNSA_WRITE_SELECT_BIT);
   localparam logic [2:0] LAST_WORD = 3'(`PNSA_SHADOW_WORDS - 1);

   typedef struct packed {
      pnsa_ctrl_state_t st;
      pnsa_cmd_t cmd;
      logic [7:0] addr;
      logic [15:0] data;
      logic [111:0] pin;
      logic [111:0] pout;
      logic [3:0] pc;
      logic [2:0] w;
      logic [3:0] bi;
      pnsa_uop_step_t u;
      logic [15:0] rd;
      logic [15:0] polls;
      logic err;
      logic ready;
      logic done;
      logic error;
      logic [15:0] rdata;
      logic op_valid;
      pnsa_byte_step_t b;
      logic tstart;
   } pnsa_ctrl_regs_t;

   pnsa_ctrl_regs_t r;
   pnsa_ctrl_regs_t next_r;
   logic adv;
   logic [3:0] last_bi;
   logic op_done;
   logic op_nack;
   logic [7:0] op_rdata;
   logic t_expired;

   function automatic pnsa_uop_step_t mk(input pnsa_uop_t k, input logic rep,
                                         input logic [7:0] a, input logic [15:0] d);
      pnsa_uop_step_t s;
      s.kind = k;
      s.rep = rep;
      s.addr = a;
      s.data = d;
      return s;
   endfunction

   // Step program of each user command; the shadow steps repeat once per word
   function automatic pnsa_uop_step_t uop_at(input pnsa_cmd_t cmd, input logic [3:0] pc,
                                             input logic [7:0] a, input logic [15:0] d,
                                             input logic [15:0] word, input logic [2:0] w);
      pnsa_uop_step_t s;
      logic massw;
      logic [7:0] shadow;
      s = mk(PNSA_UOP_END, 1'b0, 8'h00, 16'h0000);
      massw = (cmd == PNSA_CMD_MASS_WRITE);
      shadow = `PNSA_FIRST_SHADOW_ADDR + {5'h00, w};
      unique case (cmd)
         PNSA_CMD_REG_WRITE: begin
            if (pc == 4'h0) begin
               s = mk(PNSA_UOP_WR, 1'b0, a, d);
            end
         end
         PNSA_CMD_REG_READ: begin
            if (pc == 4'h0) begin
               s = mk(PNSA_UOP_RD, 1'b0, a, 16'h0000);
            end
         end
         PNSA_CMD_SLEEP: begin
            case (pc)
               4'h0: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_MOTOR_NVM_CTRL_ADDR, MOTOR_OFF);
               4'h1: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_SPEED_CMD_ADDR, SPEED_ZERO_A);
               4'h2: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_MOTOR_NVM_CTRL_ADDR,
                            `PNSA_CTRL_CLEAR);
               // Speed field zero while command_a stays set
               4'h3: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_SPEED_CMD_ADDR, SPEED_ZERO_A);
               default: s = mk(PNSA_UOP_END, 1'b0, 8'h00, 16'h0000);
            endcase
         end
         PNSA_CMD_MASS_WRITE,
         PNSA_CMD_MASS_READ: begin
            case (pc)
               4'h0: s = mk(PNSA_UOP_WAIT, 1'b0, 8'h00, 16'h0000);
               // Motor held off for the whole access, so nothing spins meanwhile
               4'h1: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_MOTOR_NVM_CTRL_ADDR,
                            MOTOR_OFF);
               4'h2: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_UNLOCK_KEY_ADDR, `PNSA_KEY_CLEAR);
               4'h3: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_UNLOCK_KEY_ADDR, `PNSA_KEY_UNLOCK);
               4'h4: s = mk(PNSA_UOP_POLL, 1'b0, `PNSA_NVM_STATUS_ADDR, 16'h0000);
               4'h5: begin
                  if (massw) begin
                     s = mk(PNSA_UOP_WR, 1'b1, shadow, word);
                  end else begin
                     s = mk(PNSA_UOP_WR, 1'b0, `PNSA_ACCESS_CTRL_ADDR, MASS_RD_CTRL);
                  end
               end
               4'h6: begin
                  if (massw) begin
                     s = mk(PNSA_UOP_WR, 1'b0, `PNSA_ACCESS_CTRL_ADDR, MASS_WR_CTRL);
                  end else begin
                     s = mk(PNSA_UOP_POLL, 1'b0, `PNSA_NVM_STATUS_ADDR, 16'h0000);
                  end
               end
               4'h7: begin
                  if (massw) begin
                     s = mk(PNSA_UOP_POLL, 1'b0, `PNSA_NVM_STATUS_ADDR, 16'h0000);
                  end else begin
                     s = mk(PNSA_UOP_RD, 1'b1, shadow, 16'h0000);
                  end
               end
               4'h8: s = mk(PNSA_UOP_WR, 1'b0, `PNSA_MOTOR_NVM_CTRL_ADDR,
                            `PNSA_CTRL_CLEAR);
               default: s = mk(PNSA_UOP_END, 1'b0, 8'h00, 16'h0000);
            endcase
         end
         default: s = mk(PNSA_UOP_END, 1'b0, 8'h00, 16'h0000);
      endcase
      return s;
   endfunction

   // Byte sequence of one register access: write is 6 steps, read 8
   function automatic pnsa_byte_step_t byte_at(input logic rd_kind, input logic [3:0] bi,
                                               input logic [7:0] a, input logic [15:0] d,
                                               input logic [6:0] dev);
      pnsa_byte_step_t b;
      b.op = PNSA_OP_STOP;
      b.wbyte = 8'h00;
      b.ack = 1'b0;
      if (!rd_kind) begin
         case (bi)
            4'h0: b.op = PNSA_OP_START;
            4'h1: b = '{op: PNSA_OP_WRITE, wbyte: {dev, 1'b0}, ack: 1'b0};
            4'h2: b = '{op: PNSA_OP_WRITE, wbyte: a, ack: 1'b0};
            4'h3: b = '{op: PNSA_OP_WRITE, wbyte: d[15:8], ack: 1'b0};
            4'h4: b = '{op: PNSA_OP_WRITE, wbyte: d[7:0], ack: 1'b0};
            default: b.op = PNSA_OP_STOP;
         endcase
      end else begin
         case (bi)
            4'h0: b.op = PNSA_OP_START;
            4'h1: b = '{op: PNSA_OP_WRITE, wbyte: {dev, 1'b0}, ack: 1'b0};
            4'h2: b = '{op: PNSA_OP_WRITE, wbyte: a, ack: 1'b0};
            4'h3: b.op = PNSA_OP_START;
            4'h4: b = '{op: PNSA_OP_WRITE, wbyte: {dev, 1'b1}, ack: 1'b0};
            4'h5: b = '{op: PNSA_OP_READ, wbyte: 8'h00, ack: 1'b1};
            4'h6: b = '{op: PNSA_OP_READ, wbyte: 8'h00, ack: 1'b0};
            default: b.op = PNSA_OP_STOP;
         endcase
      end
      return b;
   endfunction

   always_comb begin
      next_r = r;
      adv = 1'b0;
      next_r.done = 1'b0;
      next_r.op_valid = 1'b0;
      next_r.tstart = 1'b0;
      last_bi = (r.u.kind == PNSA_UOP_RD || r.u.kind == PNSA_UOP_POLL) ? 4'h7 : 4'h5;
      unique case (r.st)
         PNSA_S_IDLE: begin
            if (cmd_valid_i) begin
               next_r.cmd = cmd_kind_i;
               next_r.addr = cmd_addr_i;
               next_r.data = cmd_data_i;
               next_r.pin = param_wdata_i;
               next_r.pc = 4'h0;
               next_r.w = 3'h0;
               next_r.polls = 16'h0000;
               next_r.err = 1'b0;
               next_r.ready = 1'b0;
               next_r.st = PNSA_S_FETCH;
            end
         end
         PNSA_S_FETCH: begin
            next_r.u = uop_at(r.cmd, r.pc, r.addr, r.data, r.pin[r.w*16 +: 16], r.w);
            next_r.bi = 4'h0;
            unique case (next_r.u.kind)
               PNSA_UOP_END: next_r.st = PNSA_S_FINISH;
               PNSA_UOP_WAIT: begin
                  next_r.tstart = 1'b1;
                  next_r.st = PNSA_S_WAIT;
               end
               PNSA_UOP_WR,
               PNSA_UOP_RD,
               PNSA_UOP_POLL: next_r.st = PNSA_S_ISSUE;
            endcase
         end
         PNSA_S_WAIT: begin
            if (t_expired) begin
               adv = 1'b1;
            end
         end
         PNSA_S_ISSUE: begin
            next_r.b = byte_at(r.u.kind != PNSA_UOP_WR, r.bi, r.u.addr, r.u.data, DEV_ADDR);
            next_r.op_valid = 1'b1;
            next_r.st = PNSA_S_BUSY;
         end
         PNSA_S_BUSY: begin
            if (op_done) begin
               if (r.b.op == PNSA_OP_READ) begin
                  next_r.rd = {r.rd[7:0], op_rdata};
               end
               if (r.b.op == PNSA_OP_WRITE && op_nack) begin
                  // Unanswered byte: close the bus with a stop and report failure
                  next_r.err = 1'b1;
                  next_r.bi = last_bi;
                  next_r.st = PNSA_S_ISSUE;
               end else if (r.bi != last_bi) begin
                  next_r.bi = r.bi + 4'h1;
                  next_r.st = PNSA_S_ISSUE;
               end else if (r.err) begin
                  next_r.st = PNSA_S_FINISH;
               end else begin
                  unique case (r.u.kind)
                     PNSA_UOP_RD: begin
                        next_r.rdata = r.rd;
                        if (r.u.rep) begin
                           next_r.pout[r.w*16 +: 16] = r.rd;
                        end
                        adv = 1'b1;
                     end
                     PNSA_UOP_POLL: begin
                        if (r.rd[`PNSA_READY_FLAG_BIT]) begin
                           adv = 1'b1;
                        end else if (r.polls == 16'(POLL_LIMIT - 1)) begin
                           // Bounded poll so a dead store cannot hang the controller
                           next_r.err = 1'b1;
                           next_r.st = PNSA_S_FINISH;
                        end else begin
                           next_r.polls = r.polls + 16'h0001;
                           next_r.bi = 4'h0;
                           next_r.st = PNSA_S_ISSUE;
                        end
                     end
                     default: adv = 1'b1;
                  endcase
               end
            end
         end
         PNSA_S_FINISH: begin
            next_r.done = 1'b1;
            next_r.error = r.err;
            next_r.ready = 1'b1;
            next_r.st = PNSA_S_IDLE;
         end
      endcase
      if (adv) begin
         next_r.polls = 16'h0000;
         next_r.st = PNSA_S_FETCH;
         if (r.u.rep && r.w != LAST_WORD) begin
            next_r.w = r.w + 3'h1;
         end else begin
            next_r.w = 3'h0;
            next_r.pc = r.pc + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         r <= '0;
         r.st <= PNSA_S_IDLE;
         r.ready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   pnsa_wait_timer #(
      .CYCLES(WAKE_WAIT_CYCLES)
   ) u_wake_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .start_i(r.tstart),
      .expired_o(t_expired)
   );

   pnsa_i2c_byte #(
      .QUARTER(SCL_QUARTER)
   ) u_i2c (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .op_valid_i(r.op_valid),
      .op_i(r.b.op),
      .wdata_i(r.b.wbyte),
      .ack_send_i(r.b.ack),
      .sda_i(sda_i),
      .op_done_o(op_done),
      .op_nack_o(op_nack),
      .rdata_o(op_rdata),
      .scl_o(scl_o),
      .scl_oe_o(scl_oe_o),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o)
   );

   assign cmd_ready_o = r.ready;
   assign cmd_done_o = r.done;
   assign cmd_error_o = r.error;
   assign rdata_o = r.rdata;
   assign param_rdata_o = r.pout;

endmodule

/* hdl/pnsa_i2c_byte.sv */
`timescale 1ns/10ps
`include "pnsa_regs.svh"
module pnsa_i2c_byte
   import pnsa_pkg::*;
#(
   parameter int QUARTER = `PNSA_SCL_QUARTER_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic op_valid_i,
   input wire pnsa_i2c_op_t op_i,
   input wire logic [7:0] wdata_i,
   input wire logic ack_send_i,
   input wire logic sda_i,
   output logic op_done_o,
   output logic op_nack_o,
   output logic [7:0] rdata_o,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o
);

   typedef struct packed {
      logic busy;
      pnsa_i2c_op_t op;
      logic [5:0] step;
      logic [7:0] div;
      logic [8:0] sh;
      logic scl_low;
      logic sda_low;
      logic sync1;
      logic sync2;
      logic done;
      logic nack;
      logic [7:0] rdata;
   } pnsa_i2c_state_t;

   pnsa_i2c_state_t r;
   pnsa_i2c_state_t next_r;
   logic [5:0] last;

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.sync1 = sda_i;
      next_r.sync2 = r.sync1;
      last = (r.op == PNSA_OP_START || r.op == PNSA_OP_STOP) ? 6'h03 : 6'h23;
      if (!r.busy) begin
         if (op_valid_i) begin
            next_r.busy = 1'b1;
            next_r.op = op_i;
            next_r.step = 6'h00;
            next_r.div = 8'h00;
            // Ninth bit drives the acknowledge slot: released on writes
            next_r.sh = (op_i == PNSA_OP_READ) ? {8'hFF, ~ack_send_i} : {wdata_i, 1'b1};
         end
      end else if (r.div != 8'(QUARTER - 1)) begin
         next_r.div = r.div + 8'h01;
      end else begin
         next_r.div = 8'h00;
         unique case (r.op)
            PNSA_OP_START: begin
               // Releases data before clock so a repeated start never looks like a stop
               unique case (r.step[1:0])
                  2'h0: next_r.sda_low = 1'b0;
                  2'h1: next_r.scl_low = 1'b0;
                  2'h2: next_r.sda_low = 1'b1;
                  2'h3: next_r.scl_low = 1'b1;
               endcase
            end
            PNSA_OP_STOP: begin
               unique case (r.step[1:0])
                  2'h0: next_r.sda_low = 1'b1;
                  2'h1: next_r.scl_low = 1'b0;
                  2'h2: next_r.sda_low = 1'b0;
                  2'h3: next_r.sda_low = 1'b0;
               endcase
            end
            PNSA_OP_WRITE,
            PNSA_OP_READ: begin
               unique case (r.step[1:0])
                  2'h0: next_r.sda_low = ~r.sh[8];
                  2'h1: next_r.scl_low = 1'b0;
                  2'h2: next_r.sh = {r.sh[7:0], r.sync2};
                  2'h3: next_r.scl_low = 1'b1;
               endcase
            end
         endcase
         if (r.step == last) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.nack = r.sh[0];
            next_r.rdata = r.sh[8:1];
         end else begin
            next_r.step = r.step + 6'h01;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         r <= '0;
         r.sync1 <= 1'b1;
         r.sync2 <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign op_done_o = r.done;
   assign op_nack_o = r.nack;
   assign rdata_o = r.rdata;
   assign scl_o = 1'b0;
   assign scl_oe_o = r.scl_low;
   assign sda_o = 1'b0;
   assign sda_oe_o = r.sda_low;

endmodule

/* hdl/pnsa_pkg.sv */
package pnsa_pkg;

   typedef enum logic [2:0] {
      PNSA_CMD_REG_WRITE = 3'h0,
      PNSA_CMD_REG_READ = 3'h1,
      PNSA_CMD_MASS_WRITE = 3'h2,
      PNSA_CMD_MASS_READ = 3'h3,
      PNSA_CMD_SLEEP = 3'h4
   } pnsa_cmd_t;

   typedef enum logic [1:0] {
      PNSA_OP_START = 2'h0,
      PNSA_OP_STOP = 2'h1,
      PNSA_OP_WRITE = 2'h2,
      PNSA_OP_READ = 2'h3
   } pnsa_i2c_op_t;

   typedef enum logic [2:0] {
      PNSA_UOP_END = 3'h0,
      PNSA_UOP_WAIT = 3'h1,
      PNSA_UOP_WR = 3'h2,
      PNSA_UOP_RD = 3'h3,
      PNSA_UOP_POLL = 3'h4
   } pnsa_uop_t;

   typedef struct packed {
      pnsa_uop_t kind;
      logic rep;
      logic [7:0] addr;
      logic [15:0] data;
   } pnsa_uop_step_t;

   typedef struct packed {
      pnsa_i2c_op_t op;
      logic [7:0] wbyte;
      logic ack;
   } pnsa_byte_step_t;

   typedef enum logic [5:0] {
      PNSA_S_IDLE = 6'h01,
      PNSA_S_FETCH = 6'h02,
      PNSA_S_WAIT = 6'h04,
      PNSA_S_ISSUE = 6'h08,
      PNSA_S_BUSY = 6'h10,
      PNSA_S_FINISH = 6'h20
   } pnsa_ctrl_state_t;

endpackage

/* hdl/pnsa_regs.svh */
`ifndef PNSA_REGS_SVH
`define PNSA_REGS_SVH

// Register offsets of the driver, as seen over the two-wire bus
`define PNSA_SPEED_CMD_ADDR 8'h30
`define PNSA_UNLOCK_KEY_ADDR 8'h31
`define PNSA_NVM_STATUS_ADDR 8'h32
`define PNSA_ACCESS_CTRL_ADDR 8'h35
`define PNSA_MOTOR_NVM_CTRL_ADDR 8'h60
`define PNSA_FIRST_SHADOW_ADDR 8'h90
`define PNSA_LAST_SHADOW_ADDR 8'h96
`define PNSA_SHADOW_WORDS 7

// Field positions
`define PNSA_MOTOR_DISABLE_BIT 15
`define PNSA_COMMAND_A_BIT 15
`define PNSA_READY_FLAG_BIT 0
`define PNSA_ACCESS_KIND_LSB 0
`define PNSA_WRITE_SELECT_BIT 2
`define PNSA_RELOAD_BIT 3
`define PNSA_SHADOW_SELECT_BIT 4

// Field values
`define PNSA_ACCESS_KIND_MASS 2'h2
`define PNSA_KEY_CLEAR 16'h0000
`define PNSA_KEY_UNLOCK 16'hC0DE
`define PNSA_CTRL_CLEAR 16'h0000

// Arbitrary bus address of the driver; set to match the board
`define PNSA_DEV_ADDR 7'h52

// Timing
`define PNSA_CLK_PERIOD_NS 8
`define PNSA_WAKE_WAIT_MS 10
`define PNSA_WAKE_WAIT_CYCLES ((`PNSA_WAKE_WAIT_MS * 1000000 + `PNSA_CLK_PERIOD_NS - 1) / `PNSA_CLK_PERIOD_NS)
`define PNSA_SCL_PERIOD_NS 2500
`define PNSA_SCL_QUARTER_CYCLES ((`PNSA_SCL_PERIOD_NS + 4 * `PNSA_CLK_PERIOD_NS - 1) / (4 * `PNSA_CLK_PERIOD_NS))
`define PNSA_POLL_LIMIT 1024

`endif

/* hdl/pnsa_wait_timer.sv */
`timescale 1ns/10ps
module pnsa_wait_timer
   import pnsa_pkg::*;
#(
   parameter int CYCLES = 16
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic start_i,
   output logic expired_o
);

   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic run;
      logic [CW-1:0] cnt;
      logic expired;
   } pnsa_timer_state_t;

   pnsa_timer_state_t r;
   pnsa_timer_state_t next_r;

   always_comb begin
      next_r = r;
      next_r.expired = 1'b0;
      if (start_i) begin
         next_r.run = 1'b1;
         next_r.cnt = '0;
      end else if (r.run) begin
         if (r.cnt == CW'(CYCLES - 1)) begin
            next_r.run = 1'b0;
            next_r.expired = 1'b1;
         end else begin
            next_r.cnt = r.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign expired_o = r.expired;

endmodule

/* sim/pnsa_dev_model.sv */
`timescale 1ns/10ps
module pnsa_dev_model (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic hold_busy_i,
   input wire logic nak_i,
   output logic sda_oe_o = 1'b0
);
   logic [15:0] mem [0:255];
   logic [15:0] nvm [0:6];
   logic [15:0] tx;
   logic [7:0] sh, ra, hi;
   logic act = 1'b0, rd = 1'b0, unlocked = 1'b0, asleep = 1'b0, dis_at_copy = 1'b0;
   int bcnt = 0, idx = 0, busy = 0;
   task automatic take_byte();
      if (idx == 0) begin
         rd = sh[0];
         tx = (ra == 8'h32) ? {15'h0000, unlocked && busy == 0} : mem[ra];
      end else if (idx == 1) ra = sh;
      else if (idx == 2) hi = sh;
      else if (busy == 0) begin
         if (ra == 8'h31) unlocked = {hi, sh} == 16'hC0DE && mem[ra] == 16'h0000;
         // Sleep only once command_a already stands and the motor is enabled again
         if (ra == 8'h30 && mem[ra][15] && !mem[8'h60][15] && {hi[0], sh} == 9'h000)
            asleep = 1'b1;
         mem[ra] = {hi, sh};
         if (ra == 8'h35 && unlocked && sh[4:0] inside {5'h02, 5'h06}) begin
            dis_at_copy = mem[8'h60][15];
            busy = 40;
            for (int k = 0; k < 7; k++) begin
               if (sh[2]) nvm[k] = mem[8'h90 + k];
               else mem[8'h90 + k] = nvm[k];
            end
         end
      end
   endtask
   // Resistance and BEMF codes share one layout: shift above mantissa
   function automatic int code_steps(input logic [6:0] c);
      return int'(c[3:0]) << c[6:4];
   endfunction
   function automatic int res_mohm(input logic [6:0] c);
      return int'(code_steps(c) * 9.67);
   endfunction
   // Start and stop: data moves while the clock is high
   always @(negedge sda_i) begin
      if (scl_i) begin
         act = 1'b1;
         bcnt = 0;
         idx = 0;
      end
   end
   always @(posedge sda_i) if (scl_i) act = 1'b0;
   always @(posedge scl_i) begin
      if (busy > 0 && !hold_busy_i) busy--;
      if (bcnt < 8) begin
         sh = {sh[6:0], sda_i};
         tx = tx << 1;
      end else if (rd && sda_i) act = 1'b0;
      bcnt++;
   end
   always @(negedge scl_i) begin
      if (act && bcnt == 8) begin
         sda_oe_o = !(rd && idx > 0) && !nak_i;
         if (sda_oe_o) take_byte();
      end else if (act && bcnt == 9) begin
         bcnt = 0;
         idx++;
         sda_oe_o = rd && !tx[15];
      end else if (act && rd && idx > 0) sda_oe_o = !tx[15];
   end
endmodule

/* sim/pnsa_host_ctrl_asserts.sv */
`timescale 1ns/10ps
module pnsa_chk
   import pnsa_pkg::*;
#(
   parameter int WAKE_WAIT_CYCLES = 50
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire pnsa_cmd_t cmd_kind_i,
   input wire logic cmd_ready_o,
   input wire logic cmd_done_o,
   input wire logic cmd_error_o,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o
);
   logic take;
   logic mass;
   logic [31:0] cnt;
   assign take = cmd_valid_i && cmd_ready_o;
   // Cycles since the last take; wide enough never to wrap in a run
   always_ff @(posedge mclk_i) begin
      if (rst_i || take) begin
         cnt <= 32'h0;
         mass <= cmd_kind_i inside {PNSA_CMD_MASS_WRITE, PNSA_CMD_MASS_READ};
      end else begin
         cnt <= cnt + 32'h1;
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   take_drop_a: assert property (take |=> !cmd_ready_o)
      else $error("ready held after take");
   done_ready_a: assert property (cmd_done_o |-> cmd_ready_o && !$past(cmd_ready_o))
      else $error("done without busy phase");
   done_pulse_a: assert property (cmd_done_o |=> !cmd_done_o)
      else $error("done too long");
   bad_kind_a: assert property (take && cmd_kind_i > PNSA_CMD_SLEEP |-> ##[1:8] (cmd_done_o && !cmd_error_o))
      else $error("unknown command not finished");
   idle_bus_a: assert property (cmd_ready_o |-> !scl_oe_o && !sda_oe_o)
      else $error("bus held while idle");
   err_hold_a: assert property (!cmd_done_o |-> $stable(cmd_error_o))
      else $error("error changed without done");
   wake_wait_a: assert property (mass && $rose(sda_oe_o) |-> cnt >= WAKE_WAIT_CYCLES)
      else $error("bus used before wake wait");
   scl_low_a: assert property ($rose(scl_oe_o) |=> scl_oe_o [*3])
      else $error("clock low phase too short");
endmodule
bind pnsa_host_ctrl pnsa_chk #(.WAKE_WAIT_CYCLES(WAKE_WAIT_CYCLES)) chk_u (.mclk_i, .rst_i,
   .cmd_valid_i, .cmd_kind_i, .cmd_ready_o, .cmd_done_o, .cmd_error_o, .scl_oe_o, .sda_oe_o);

/* sim/tb.sv */
`timescale 1ns/10ps
module tb
   import pnsa_pkg::*;
;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   pnsa_cmd_t cmd_kind_i = PNSA_CMD_REG_WRITE;
   logic [7:0] cmd_addr_i = 8'h00;
   logic [15:0] cmd_data_i = 16'h0000;
   logic [111:0] param_wdata_i = 112'h0;
   logic hold = 1'b0;
   logic nak = 1'b0;
   logic cmd_ready_o, cmd_done_o, cmd_error_o, scl_o, scl_oe_o, sda_o, sda_oe_o, dev_oe;
   logic [15:0] rdata_o;
   logic [111:0] param_rdata_o, v;
   logic [127:0] r;
   logic [7:0] a;
   int seed = 66626;
   int error_cnt = 0;
   int checks = 0;
   // Open-drain wires with pull-ups
   wire logic scl_w = !scl_oe_o;
   wire logic sda_w = !(sda_oe_o || dev_oe);
   always #4 mclk_i = !mclk_i;
   pnsa_host_ctrl #(.WAKE_WAIT_CYCLES(50), .POLL_LIMIT(8), .SCL_QUARTER(4)) dut_u (
      .mclk_i, .rst_i, .cmd_valid_i, .cmd_kind_i, .cmd_addr_i, .cmd_data_i, .param_wdata_i,
      .sda_i(sda_w), .cmd_ready_o, .cmd_done_o, .cmd_error_o, .rdata_o, .param_rdata_o,
      .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);
   pnsa_dev_model dev_u (.scl_i(scl_w), .sda_i(sda_w), .hold_busy_i(hold), .nak_i(nak),
      .sda_oe_o(dev_oe));
   function automatic logic [111:0] nvm_img();
      logic [111:0] x;
      for (int k = 0; k < 7; k++) x[16*k +: 16] = dev_u.nvm[k];
      return x;
   endfunction
   task automatic chk(input string n, input logic [111:0] e, input logic [111:0] s);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic run(input pnsa_cmd_t k, input logic [7:0] ad, input logic [15:0] d);
      int n;
      n = 0;
      cmd_kind_i <= k;
      cmd_addr_i <= ad;
      cmd_data_i <= d;
      cmd_valid_i <= 1'b1;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      @(negedge mclk_i);
      while (cmd_done_o !== 1'b1 && n < 30000) begin
         @(negedge mclk_i);
         n++;
      end
      chk("done", 112'h1, 112'(cmd_done_o));
      @(posedge mclk_i);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      for (int k = 5; k < 8; k++) begin
         run(pnsa_cmd_t'(k[2:0]), 8'h00, 16'h0000);
         chk("err", 112'h0, 112'(cmd_error_o));
      end
      // Unanswered address byte must end in a stop with the error flag set
      nak <= 1'b1;
      run(PNSA_CMD_REG_WRITE, 8'h90, 16'h1234);
      chk("nak", 112'h1, 112'(cmd_error_o));
      nak <= 1'b0;
      chk("rmax", 112'h780, 112'(dev_u.code_steps(7'h7F)));
      chk("rmin", 112'h1D, 112'(dev_u.res_mohm(7'h03)));
      repeat (4) begin
         r = {$random(seed), $random(seed), $random(seed), $random(seed)};
         a = 8'h90 + 8'(r[2:0] % 3'h7);
         run(PNSA_CMD_REG_WRITE, a, r[31:16]);
         run(PNSA_CMD_REG_READ, a, 16'h0000);
         chk("rdata", 112'(r[31:16]), 112'(rdata_o));
      end
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      param_wdata_i <= r[111:0];
      run(PNSA_CMD_MASS_WRITE, 8'h00, 16'h0000);
      chk("nvm", r[111:0], nvm_img());
      chk("dis", 112'h1, 112'(dev_u.dis_at_copy));
      chk("motor", 112'h0, 112'(dev_u.mem[8'h60]));
      chk("err", 112'h0, 112'(cmd_error_o));
      chk("pins", 112'h0, 112'({scl_o, sda_o}));
      v = 112'({$random(seed), $random(seed), $random(seed), $random(seed)});
      for (int k = 0; k < 7; k++) dev_u.nvm[k] = v[16*k +: 16];
      run(PNSA_CMD_MASS_READ, 8'h00, 16'h0000);
      chk("shadow", v, param_rdata_o);
      chk("last", 112'(v[111:96]), 112'(rdata_o));
      run(PNSA_CMD_SLEEP, 8'h00, 16'h0000);
      chk("sleep", 112'h1, 112'(dev_u.asleep));
      chk("motor", 112'h0, 112'(dev_u.mem[8'h60]));
      hold <= 1'b1;
      run(PNSA_CMD_MASS_WRITE, 8'h00, 16'h0000);
      chk("err", 112'h1, 112'(cmd_error_o));
      chk("motor", 112'h8000, 112'(dev_u.mem[8'h60]));
      summarize();
   end
   initial begin
      repeat (100000) @(posedge mclk_i);
      error_cnt++;
      summarize();
   end
endmodule
